// ===== logic/eipu_pkg.sv
/*
  Constants shared by the external pin interrupt unit: register offsets,
  bit positions, reset values and the sense mode encoding.
  Assumes an 8-bit register port with a 4-bit word address.
*/
package eipu_pkg;

  // Register port geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_ENABLE = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h1;
  localparam logic [3:0] OFS_MCU_CSR = 4'h2;
  localparam logic [3:0] OFS_MCU_CTRL = 4'h3;

  // Line indices used for request, acknowledge and vector numbering.
  localparam int LINE_A = 0;
  localparam int LINE_B = 1;
  localparam int LINE_C = 2;

  // Enable bits in ext_irq_enable.
  localparam int EN_B_BIT = 7;
  localparam int EN_A_BIT = 6;
  localparam int EN_C_BIT = 5;

  // Pending bits in ext_irq_flags.
  localparam int PEND_B_BIT = 7;
  localparam int PEND_A_BIT = 6;
  localparam int PEND_C_BIT = 5;

  // Edge select of line c in mcu_ctrl_status.
  localparam int EDGE_SEL_C_BIT = 6;

  // Sense pairs in mcu_control_word: line a in bits 1:0, line b in bits 3:2.
  localparam int SENSE_A_LSB = 0;
  localparam int SENSE_B_LSB = 2;
  localparam int SENSE_W = 4;

  // Reset values.
  localparam logic [2:0] EN_RST = 3'h0;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic EDGE_SEL_C_RST = 1'b0;
  localparam logic [3:0] SENSE_RST = 4'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [1:0] VEC_RST = 2'h0;

  // Sense pair encoding for lines a and b, in encoding order 00 to 11.
  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_ANY,
    SENSE_FALL,
    SENSE_RISE
  } eipu_sense_t;

endpackage : eipu_pkg

// ===== logic/eipu_edge_sense.sv
/*
  Clocked edge detector for one of the lines a and b.
  Assumes the pin is synchronous to mclk_in; level mode is handled by the caller.
*/
`timescale 1ns/1ns
module eipu_edge_sense (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Pin and mode.
  input wire logic pin_in,
  input eipu_pkg::eipu_sense_t mode_in,
  // One-cycle event.
  output logic event_out
);

  logic prev_q;
  logic prev_d;

  // Previous sample of the pin; a pulse longer than one period is always seen.
  always_comb begin
    prev_d = pin_in;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Event decode by mode; low level gives no event here.
  always_comb begin
    case (mode_in)
      eipu_pkg::SENSE_ANY: event_out = pin_in ^ prev_q;
      eipu_pkg::SENSE_FALL: event_out = prev_q & ~pin_in;
      eipu_pkg::SENSE_RISE: event_out = pin_in & ~prev_q;
      default: event_out = 1'b0;
    endcase
  end

endmodule : eipu_edge_sense

// ===== logic/eipu_async_edge.sv
/*
  Clockless edge capture for line c plus its crossing into mclk_in.
  Assumes the selected edge changes slower than about three clock periods.
*/
`timescale 1ns/1ns
module eipu_async_edge (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Pin and edge select.
  input wire logic pin_in,
  input wire logic edge_sel_in,
  // One-cycle event in the mclk_in domain.
  output logic event_out
);

  logic cap_clk;
  logic tog_q;
  logic tog_d;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;

  // Inverting for falling edges turns every selected edge into a rising one.
  // Flipping edge_sel_in can itself make such an edge, hence the spurious event.
  assign cap_clk = pin_in ^ ~edge_sel_in;

  always_comb begin
    tog_d = ~tog_q;
  end

  // The pin edge clocks this flop, so no clock is needed to catch a short pulse.
  always_ff @(posedge cap_clk or negedge rstn_in) begin
    if (!rstn_in) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end

  // Two-stage synchronizer for the toggle, then a third stage for change detect.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= tog_q;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign event_out = sync2_q ^ sync3_q;

endmodule : eipu_async_edge

// ===== logic/eipu_top.sv
/*
  External pin interrupt unit: three pins, pending flags, enables, sense
  control, per-line requests and a vector number for the core.
  Assumes a core that supplies its global enable and pulses an acknowledge
  when it enters a line's service routine; pins a and b are synchronous.
*/
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module eipu_top (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Register port.
  input wire logic [eipu_pkg::ADDR_W-1:0] addr_in,
  input wire logic [eipu_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [eipu_pkg::DATA_W-1:0] rdata_out,
  // Core side.
  input wire logic gie_in,
  input wire logic [2:0] ack_in,
  output logic [2:0] irq_req_out,
  output logic vec_valid_out,
  output logic [1:0] vec_out,
  // Pins and sleep control.
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  input wire logic pin_c_in,
  input wire logic sleep_buf_off_in
);

  logic [2:0] en_q;
  logic [2:0] en_d;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic edge_sel_c_q;
  logic edge_sel_c_d;
  logic [eipu_pkg::SENSE_W-1:0] sense_q;
  logic [eipu_pkg::SENSE_W-1:0] sense_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [2:0] req_q;
  logic [2:0] req_d;
  logic vec_valid_q;
  logic vec_valid_d;
  logic [1:0] vec_q;
  logic [1:0] vec_d;
  logic [2:0] ev;
  logic [2:0] lvl;
  logic [2:0] gate;
  logic [2:0] pins;
  logic [2:0] clr;
  logic pin_c_eff;
  logic wr_enable;
  logic wr_flags;
  eipu_pkg::eipu_sense_t mode [2];

  // Scatter three line bits to their register positions.
  function automatic logic [7:0] eipu_pack(input logic [2:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[eipu_pkg::EN_A_BIT] = v[eipu_pkg::LINE_A];
    r[eipu_pkg::EN_B_BIT] = v[eipu_pkg::LINE_B];
    r[eipu_pkg::EN_C_BIT] = v[eipu_pkg::LINE_C];
    return r;
  endfunction : eipu_pack

  // Gather line bits from a written byte; pending and enable share positions.
  function automatic logic [2:0] eipu_unpack(input logic [7:0] b);
    logic [2:0] r;
    r = 3'h0;
    r[eipu_pkg::LINE_A] = b[eipu_pkg::PEND_A_BIT];
    r[eipu_pkg::LINE_B] = b[eipu_pkg::PEND_B_BIT];
    r[eipu_pkg::LINE_C] = b[eipu_pkg::PEND_C_BIT];
    return r;
  endfunction : eipu_unpack

  // Address decode of the write strobe.
  assign wr_enable = wr_in && (addr_in == eipu_pkg::OFS_ENABLE);
  assign wr_flags = wr_in && (addr_in == eipu_pkg::OFS_FLAGS);

  // Pins are read as levels whatever the port direction, so software can
  // drive a pin as an output and raise its own interrupt.
  assign pins = {pin_c_eff, pin_b_in, pin_a_in};

  // A disabled line c loses its input buffer in sleep; the forced low level
  // is a real internal change and may set the flag, as on silicon.
  assign pin_c_eff = pin_c_in & ~(sleep_buf_off_in & ~en_q[eipu_pkg::LINE_C]);

  // Sense modes of lines a and b.
  assign mode[0] = eipu_pkg::eipu_sense_t'(sense_q[eipu_pkg::SENSE_A_LSB +: 2]);
  assign mode[1] = eipu_pkg::eipu_sense_t'(sense_q[eipu_pkg::SENSE_B_LSB +: 2]);

  // Clocked detectors for lines a and b.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sense
      eipu_edge_sense u_sense (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .pin_in(pins[gi]),
        .mode_in(mode[gi]),
        .event_out(ev[gi])
      );
      assign lvl[gi] = (mode[gi] == eipu_pkg::SENSE_LOW);
    end
  endgenerate

  // Line c is edge only and never in level mode.
  assign lvl[eipu_pkg::LINE_C] = 1'b0;

  eipu_async_edge u_line_c (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .pin_in(pin_c_eff),
    .edge_sel_in(edge_sel_c_q),
    .event_out(ev[eipu_pkg::LINE_C])
  );

  // A line may only request while its own enable and the global enable hold.
  assign gate = en_q & {3{gie_in}};

  // Clear sources: a one written to the flag or the core entering the routine.
  assign clr = (wr_flags ? eipu_unpack(wdata_in) : 3'h0) | ack_in;

  // Configuration registers; fields outside the block read as zero.
  always_comb begin
    en_d = en_q;
    edge_sel_c_d = edge_sel_c_q;
    sense_d = sense_q;
    if (wr_enable) begin
      en_d = eipu_unpack(wdata_in);
    end
    if (wr_in && (addr_in == eipu_pkg::OFS_MCU_CSR)) begin
      edge_sel_c_d = wdata_in[eipu_pkg::EDGE_SEL_C_BIT];
    end
    if (wr_in && (addr_in == eipu_pkg::OFS_MCU_CTRL)) begin
      sense_d = wdata_in[eipu_pkg::SENSE_W-1:0];
    end
  end

  // Pending flags: a new trigger beats a clear in the same cycle, and level
  // mode holds the flag at zero so stale edges cannot linger.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (lvl[i]) begin
        flag_d[i] = 1'b0;
      end else if (ev[i]) begin
        flag_d[i] = 1'b1;
      end else if (clr[i]) begin
        flag_d[i] = 1'b0;
      end else begin
        flag_d[i] = flag_q[i];
      end
    end
  end

  // Edge-mode requests follow the next flag so an acknowledge drops the request at once; level-mode requests follow the pin.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (lvl[i]) begin
        req_d[i] = gate[i] & ~pins[i];
      end else begin
        req_d[i] = gate[i] & flag_d[i];
      end
    end
    // Fixed priority a, b, c; each line names its own vector.
    vec_valid_d = |req_d;
    if (req_d[eipu_pkg::LINE_A]) begin
      vec_d = 2'(eipu_pkg::LINE_A);
    end else if (req_d[eipu_pkg::LINE_B]) begin
      vec_d = 2'(eipu_pkg::LINE_B);
    end else if (req_d[eipu_pkg::LINE_C]) begin
      vec_d = 2'(eipu_pkg::LINE_C);
    end else begin
      vec_d = eipu_pkg::VEC_RST;
    end
  end

  // Read data for one cycle after the strobe, zero otherwise.
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        eipu_pkg::OFS_ENABLE: rdata_d = eipu_pack(en_q);
        eipu_pkg::OFS_FLAGS: rdata_d = eipu_pack(flag_q & ~lvl);
        eipu_pkg::OFS_MCU_CSR: rdata_d[eipu_pkg::EDGE_SEL_C_BIT] = edge_sel_c_q;
        eipu_pkg::OFS_MCU_CTRL: rdata_d[eipu_pkg::SENSE_W-1:0] = sense_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_q <= eipu_pkg::EN_RST;
      flag_q <= eipu_pkg::FLAG_RST;
      edge_sel_c_q <= eipu_pkg::EDGE_SEL_C_RST;
      sense_q <= eipu_pkg::SENSE_RST;
      rdata_q <= eipu_pkg::RDATA_RST;
      req_q <= 3'h0;
      vec_valid_q <= 1'b0;
      vec_q <= eipu_pkg::VEC_RST;
    end else begin
      en_q <= en_d;
      flag_q <= flag_d;
      edge_sel_c_q <= edge_sel_c_d;
      sense_q <= sense_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      vec_valid_q <= vec_valid_d;
      vec_q <= vec_d;
    end
  end

  assign rdata_out = rdata_q;
  assign irq_req_out = req_q;
  assign vec_valid_out = vec_valid_q;
  assign vec_out = vec_q;

  // Checks on the block's own outputs and state.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_rise_a;
    (mode[0] == eipu_pkg::SENSE_RISE) && $rose(pin_a_in);
  endsequence

  sequence s_set_a;
    flag_q[0] && irq_req_out[0] == $past(gate[0]);
  endsequence

  property p_req_c_gated;
    irq_req_out[2] |-> $past(gate[2]);
  endproperty
  a_req_c_gated: assert property (p_req_c_gated) else $error("line c request without enables");

  property p_rise_a_sets;
    s_rise_a and (mode[0] == eipu_pkg::SENSE_RISE)[*1] |=> s_set_a;
  endproperty
  a_rise_a_sets: assert property (p_rise_a_sets) else $error("rising edge on line a missed");

  property p_fall_b_sets;
    (mode[1] == eipu_pkg::SENSE_FALL) && $fell(pin_b_in) |=> flag_q[1];
  endproperty
  a_fall_b_sets: assert property (p_fall_b_sets) else $error("falling edge on line b missed");

  property p_level_keeps;
    lvl[0] && gate[0] && !pin_a_in |=> irq_req_out[0] && !flag_q[0];
  endproperty
  a_level_keeps: assert property (p_level_keeps) else $error("level request on line a dropped");

  property p_level_reads_clear;
    rd_in && (addr_in == eipu_pkg::OFS_FLAGS) && lvl[1] |=> !rdata_out[eipu_pkg::PEND_B_BIT];
  endproperty
  a_level_reads_clear: assert property (p_level_reads_clear) else $error("level line b flag read set");

  property p_ack_clears;
    flag_q[2] && ack_in[2] && !ev[2] |=> !flag_q[2] && !irq_req_out[2];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledge left line c pending");

  property p_set_beats_clear;
    ev[0] && !lvl[0] && wr_flags && wdata_in[eipu_pkg::PEND_A_BIT] |=> flag_q[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost to clear on line a");

  property p_write_zero_keeps;
    flag_q[1] && !lvl[1] && wr_flags && !wdata_in[eipu_pkg::PEND_B_BIT] && !ack_in[1] |=> flag_q[1];
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("writing zero cleared line b");

  property p_vector_match;
    vec_valid_out |-> irq_req_out[vec_out] && (vec_out == 2'h0 || !irq_req_out[0]);
  endproperty
  a_vector_match: assert property (p_vector_match) else $error("vector does not name a requesting line");

  property p_c_event_flag;
    ev[2] |=> flag_q[2] ##1 (flag_q[2] || $past(clr[2]));
  endproperty
  a_c_event_flag: assert property (p_c_event_flag) else $error("line c capture did not set flag");

  property p_read_window;
    !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  a_read_window: assert property (p_read_window) else $error("read data outside its cycle");

endmodule : eipu_top

// ===== bench/eipu_pin_model.sv
/*
  Board-side model of the three external interrupt pins.
  Assumes pins a and b are sampled on mclk_in and pin c may move at any time.
*/
`timescale 1ns/1ns
module eipu_pin_model (
  // Clock.
  input wire logic mclk_in,
  // Pins towards the unit.
  output logic pin_a_out,
  output logic pin_b_out,
  output logic pin_c_out
);
  // Pins idle high, so the low level mode that follows reset requests nothing.
  initial begin
    pin_a_out = 1'b1;
    pin_b_out = 1'b1;
    pin_c_out = 1'b1;
  end

  // Lines a and b move just after an edge and hold for several cycles.
  task automatic set_ab(input int idx, input logic v);
    @(posedge mclk_in);
    if (idx == 0) begin
      pin_a_out <= v;
    end else begin
      pin_b_out <= v;
    end
  endtask : set_ab

  // Line c pulses sit off the clock grid and never fall below 50 ns.
  task automatic pulse_c(input logic lvl, input int width_ns);
    #3;
    pin_c_out = lvl;
    #(width_ns < 50 ? 50 : width_ns);
    pin_c_out = ~lvl;
  endtask : pulse_c
endmodule : eipu_pin_model

// ===== bench/external_pin_interrupt_unit_test.sv
/*
  Self-checking bench for the external pin interrupt unit.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ns
module external_pin_interrupt_unit_test;
  logic mclk_in;
  logic rstn_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [7:0] rdata_out;
  logic gie_in;
  logic [2:0] ack_in;
  logic [2:0] irq_req_out;
  logic vec_valid_out;
  logic [1:0] vec_out;
  logic pin_a;
  logic pin_b;
  logic pin_c;
  logic sleep_buf_off_in;
  int bad_count;
  int check_count;

  // Unit under test and the board that drives its pins.
  eipu_top eipu_top_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gie_in(gie_in), .ack_in(ack_in),
    .irq_req_out(irq_req_out), .vec_valid_out(vec_valid_out), .vec_out(vec_out), .pin_a_in(pin_a),
    .pin_b_in(pin_b), .pin_c_in(pin_c), .sleep_buf_off_in(sleep_buf_off_in));
  eipu_pin_model eipu_pin_model_i (.mclk_in(mclk_in), .pin_a_out(pin_a), .pin_b_out(pin_b),
    .pin_c_out(pin_c));

  // Free-running 100 MHz clock.
  initial begin
    mclk_in = 1'b0;
  end
  always #5 mclk_in = ~mclk_in;

  // Single place where the run ends.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is taken in the cycle after it only.
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(nm, rdata_out, exp);
  endtask : rdchk

  // Let a fixed number of edges pass.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  // Main test sequence.
  initial begin
    int sh;
    logic [7:0] fb;
    logic st;
    rstn_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    gie_in = 1'b0;
    ack_in = 3'b000;
    sleep_buf_off_in = 1'b0;
    bad_count = 0;
    check_count = 0;
    cyc(3);
    rstn_in <= 1'b1;
    // Reset values, unmapped place and stored bits only.
    for (int i = 0; i < 5; i++) begin
      rdchk(i[3:0], 8'h00, "reset");
    end
    wr(4'h4, 8'hFF);
    rdchk(4'h4, 8'h00, "unmapped");
    wr(eipu_pkg::OFS_ENABLE, 8'hFF);
    rdchk(eipu_pkg::OFS_ENABLE, 8'hE0, "enable");
    wr(eipu_pkg::OFS_MCU_CSR, 8'hFF);
    rdchk(eipu_pkg::OFS_MCU_CSR, 8'h40, "edge_sel");
    wr(eipu_pkg::OFS_MCU_CSR, 8'h00);
    cyc(6);
    wr(eipu_pkg::OFS_FLAGS, 8'hE0);
    @(posedge mclk_in) gie_in <= 1'b1;
    // Every edge mode on lines a and b, then the opposite transition.
    for (int ln = 0; ln < 2; ln++) begin
      for (int m = 1; m < 4; m++) begin
        sh = (ln == 1) ? eipu_pkg::SENSE_B_LSB : eipu_pkg::SENSE_A_LSB;
        fb = 8'h01 << ((ln == 1) ? eipu_pkg::PEND_B_BIT : eipu_pkg::PEND_A_BIT);
        st = (m == 2);
        eipu_pin_model_i.set_ab(ln, st);
        cyc(3);
        wr(eipu_pkg::OFS_MCU_CTRL, 8'(m) << sh);
        wr(eipu_pkg::OFS_FLAGS, 8'hE0);
        eipu_pin_model_i.set_ab(ln, ~st);
        cyc(3);
        chk("req_ab", {7'h00, irq_req_out[ln]}, 8'h01);
        rdchk(eipu_pkg::OFS_FLAGS, fb, "flag_ab");
        wr(eipu_pkg::OFS_FLAGS, fb);
        eipu_pin_model_i.set_ab(ln, st);
        cyc(3);
        rdchk(eipu_pkg::OFS_FLAGS, (m == 1) ? fb : 8'h00, "back_ab");
        wr(eipu_pkg::OFS_FLAGS, 8'hE0);
      end
    end
    // An edge on line a in the same cycle as a write-one clear keeps the flag.
    wr(eipu_pkg::OFS_MCU_CTRL, 8'h03);
    fork
      eipu_pin_model_i.set_ab(0, 1'b1);
      wr(eipu_pkg::OFS_FLAGS, 8'h40);
    join
    rdchk(eipu_pkg::OFS_FLAGS, 8'h40, "set_wins");
    // Low level mode on line a: requests while low, flag reads cleared.
    eipu_pin_model_i.set_ab(0, 1'b1);
    eipu_pin_model_i.set_ab(1, 1'b1);
    cyc(3);
    wr(eipu_pkg::OFS_MCU_CTRL, 8'h00);
    eipu_pin_model_i.set_ab(0, 1'b0);
    cyc(5);
    chk("level_req", {7'h00, irq_req_out[0]}, 8'h01);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h00, "level_flag");
    eipu_pin_model_i.set_ab(0, 1'b1);
    cyc(3);
    chk("level_off", {7'h00, irq_req_out[0]}, 8'h00);
    // Global enable gates line b; acknowledge clears its flag.
    @(posedge mclk_in) gie_in <= 1'b0;
    eipu_pin_model_i.set_ab(1, 1'b0);
    wr(eipu_pkg::OFS_MCU_CTRL, 8'h0C);
    wr(eipu_pkg::OFS_FLAGS, 8'hE0);
    eipu_pin_model_i.set_ab(1, 1'b1);
    cyc(3);
    chk("gie_off", {5'h00, irq_req_out}, 8'h00);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h80, "flag_b");
    wr(eipu_pkg::OFS_FLAGS, 8'h00);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h80, "zero_b");
    @(posedge mclk_in) gie_in <= 1'b1;
    cyc(3);
    chk("req_b", {5'h00, irq_req_out}, 8'h02);
    chk("vec_b", {5'h00, vec_valid_out, vec_out}, 8'h05);
    @(posedge mclk_in) ack_in <= 3'b010;
    @(posedge mclk_in) ack_in <= 3'b000;
    cyc(2);
    chk("ack_b", {5'h00, irq_req_out}, 8'h00);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h00, "ack_flag");
    // Line c: falling edge, writing zero keeps the flag, acknowledge clears.
    eipu_pin_model_i.pulse_c(1'b0, 60);
    cyc(8);
    chk("req_c", {5'h00, irq_req_out}, 8'h04);
    chk("vec_c", {5'h00, vec_valid_out, vec_out}, 8'h06);
    wr(eipu_pkg::OFS_FLAGS, 8'h00);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h20, "flag_c");
    @(posedge mclk_in) ack_in <= 3'b100;
    @(posedge mclk_in) ack_in <= 3'b000;
    cyc(2);
    chk("ack_c", {5'h00, irq_req_out}, 8'h00);
    // Safe change to rising edge: disable, change, clear, re-enable.
    wr(eipu_pkg::OFS_ENABLE, 8'hC0);
    wr(eipu_pkg::OFS_MCU_CSR, 8'h40);
    cyc(6);
    wr(eipu_pkg::OFS_FLAGS, 8'h20);
    wr(eipu_pkg::OFS_ENABLE, 8'hE0);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h00, "spurious");
    eipu_pin_model_i.pulse_c(1'b1, 60);
    cyc(8);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h00, "fall_c");
    eipu_pin_model_i.pulse_c(1'b0, 60);
    cyc(8);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h20, "rise_c");
    chk("rise_req", {5'h00, irq_req_out}, 8'h04);
    // Sleep buffer cut with line c disabled sets its flag but no request.
    wr(eipu_pkg::OFS_ENABLE, 8'h00);
    wr(eipu_pkg::OFS_MCU_CSR, 8'h00);
    cyc(6);
    wr(eipu_pkg::OFS_FLAGS, 8'h20);
    @(posedge mclk_in) sleep_buf_off_in <= 1'b1;
    cyc(8);
    rdchk(eipu_pkg::OFS_FLAGS, 8'h20, "sleep");
    chk("sleep_req", {5'h00, irq_req_out}, 8'h00);
    @(posedge mclk_in) sleep_buf_off_in <= 1'b0;
    cyc(8);
    end_sim();
  end
endmodule : external_pin_interrupt_unit_test
